// ### dv/uart_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module uart_core_chk
   import uart_pkg::*;
(
   // Clock, reset and bus
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   input wire logic [31:0] hwdata,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Serial pins and request
   input wire logic        serial_in_pin,
   input wire logic        serial_out_pin,
   input wire logic        irq
);
   logic        aw_q, rd_q, en_q, fresh_q;
   logic [7:0]  a_q;
   logic [6:0]  ie_q;
   logic [12:0] md_q;
   logic [11:0] rt_q, lo_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Shadow of configuration and low run length
   always_ff @(posedge clk)
   begin
      aw_q <= rstn && hsel && hready && htrans[1] && hwrite;
      rd_q <= rstn && hsel && hready && htrans[1] && !hwrite;
      a_q <= haddr;
      lo_q <= (serial_out_pin || !rstn) ? 12'h000 : lo_q + 12'h001;
      if (!rstn)
      begin
         en_q <= 1'b0;
         ie_q <= 7'h00;
         md_q <= 13'h0000;
         rt_q <= 12'h000;
         fresh_q <= 1'b1;
      end
      else if (aw_q)
      begin
         if (a_q == control_addr) en_q <= hwdata[0];
         if (a_q == enable_addr) ie_q <= hwdata[6:0];
         if (a_q == tx_data_addr) fresh_q <= 1'b0;
         if (a_q == mode_addr && !en_q) md_q <= hwdata[12:0];
         if (a_q == rate_addr && !en_q) rt_q <= hwdata[11:0];
      end
   end
   sequence line_rise;
      $rose(serial_out_pin) ##0 rt_q == 12'h000 && !md_q[car_en_pos];
   endsequence
   zero_wait_a: assert property (hreadyout) else $error("bus wait inserted");
   okay_resp_a: assert property (!hresp) else $error("bus error response");
   rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0) else $error("read data outside read");
   reset_idle_a: assert property (disable iff (1'b0) !rstn |=> serial_out_pin && !irq)
      else $error("outputs not idle after reset");
   irq_off_a: assert property (ie_q == 7'h00 && $past(ie_q) == 7'h00 |-> !irq)
      else $error("request without enable");
   tbe_irq_a: assert property ($rose(ie_q[f_tbe]) && fresh_q |-> ##[0:2] irq)
      else $error("empty request missing");
   bit_width_a: assert property (line_rise ##0 !md_q[ir_pos] |-> lo_q[3:0] == 4'h0)
      else $error("low run not whole bits");
   ir_pulse_a: assert property (line_rise ##0 md_q[ir_pos] |-> lo_q == 12'h003)
      else $error("infrared pulse width wrong");
endmodule
bind uart_core uart_core_chk uart_core_chk_i(.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
   .irq(irq));
`default_nettype wire

// ### dv/uart_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uart_core_tb
   import uart_pkg::*;
;
   logic        clk, rstn, hsel, hwrite;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, r;
   wire logic [31:0] hrdata;
   wire logic   hrdy, hresp, sin, sout, irq;
   int          fails = 0;
   int          check_count = 0;
   int          gap;
   always #5 clk = ~clk;
   uart_core uart_core_i(.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hrdy), .hresp(hresp), .serial_in_pin(sin), .serial_out_pin(sout), .irq(irq));
   uart_far_end uart_far_end_i(.clk(clk), .line_in(sout), .line_out(sin));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One single AHB-Lite transfer
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1 && ++n < 20);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1 && ++n < 40);
      r = hrdata;
      if (n >= 20)
      begin
         fails++;
         tally_and_finish;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      bus(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      do bus(1'b0, flag_addr, 32'h0); while (r[b] !== 1'b1 && ++n < 500);
      if (n >= 500)
      begin
         fails++;
         tally_and_finish;
      end
   endtask
   task automatic cfg(input logic [31:0] m);
      wr(control_addr, 32'h0);
      wr(mode_addr, m);
      wr(rate_addr, 32'h0);
      wr(carrier_addr, 32'h0);
      wr(control_addr, 32'h2);
      wr(control_addr, 32'h1);
   endtask
   task automatic irq_is(input logic e);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask
   // Clocks between the first two rising edges of the output
   task automatic rise_gap(output int g);
      logic p;
      int   e;
      int   k;
      p = 1'b1;
      e = 0;
      k = 0;
      g = 0;
      for (int i = 0; i < 300; i++)
      begin
         @(posedge clk);
         if (sout === 1'b1 && p === 1'b0)
         begin
            k++;
            if (k == 1) e = i;
            if (k == 2) g = i - e;
         end
         p = sout;
      end
   endtask
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 8'h00;
      htrans = 2'b00;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rd(flag_addr, 32'h37f, 32'h001);
      rd(8'h24, 32'hffffffff, 32'h0);
      cfg(32'h008);
      wr(enable_addr, 32'h01);
      irq_is(1'b1);
      wr(enable_addr, 32'h00);
      irq_is(1'b0);
      $display("test reset and request done");
      wr(tx_data_addr, 32'ha5);
      wait_flag(f_tbe);
      wr(tx_data_addr, 32'h3c);
      wait_flag(f_tend);
      rd(flag_addr, 32'h141, 32'h041);
      chk(uart_far_end_i.got_q.size(), 2);
      chk(uart_far_end_i.got_q[0], 32'ha5);
      chk(uart_far_end_i.got_q[1], 32'h3c);
      wr(enable_addr, 32'h40);
      irq_is(1'b1);
      wr(flag_addr, 32'h40);
      irq_is(1'b0);
      wr(enable_addr, 32'h00);
      $display("test transmit done");
      uart_far_end_i.send(8'h5a, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(flag_addr, 32'h206, 32'h002);
      uart_far_end_i.send(8'hc3, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(flag_addr, 32'h006, 32'h006);
      uart_far_end_i.send(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(flag_addr, 32'h00e, 32'h00e);
      rd(rx_data_addr, 32'hff, 32'h5a);
      rd(rx_data_addr, 32'hff, 32'hc3);
      rd(flag_addr, 32'h006, 32'h0);
      wr(flag_addr, 32'h08);
      rd(flag_addr, 32'h008, 32'h0);
      uart_far_end_i.send(8'h44, 1'b0, 1'b0, 1'b0, 1'b0);
      uart_far_end_i.send(8'h55, 1'b0, 1'b0, 1'b0, 1'b1);
      rd(flag_addr, 32'h026, 32'h006);
      rd(rx_data_addr, 32'hff, 32'h44);
      rd(flag_addr, 32'h020, 32'h020);
      rd(rx_data_addr, 32'hff, 32'h55);
      rd(flag_addr, 32'h020, 32'h0);
      $display("test receive done");
      cfg(32'h00e);
      wr(mode_addr, 32'h01f);
      rd(mode_addr, 32'hffffffff, 32'h00e);
      uart_far_end_i.send(8'h31, 1'b1, 1'b1, 1'b1, 1'b0);
      rd(flag_addr, 32'h010, 32'h010);
      rd(rx_data_addr, 32'hff, 32'h31);
      uart_far_end_i.send(8'h32, 1'b1, 1'b1, 1'b0, 1'b0);
      rd(flag_addr, 32'h010, 32'h0);
      rd(rx_data_addr, 32'hff, 32'h32);
      cfg(32'h001);
      uart_far_end_i.send(8'hc5, 1'b0, 1'b0, 1'b0, 1'b0);
      rd(flag_addr, 32'h020, 32'h0);
      rd(rx_data_addr, 32'hff, 32'h45);
      $display("test format done");
      cfg(32'h018);
      wr(tx_data_addr, 32'h96);
      wait_flag(f_tend);
      $display("test infrared done");
      cfg(32'h808);
      wr(carrier_addr, 32'h03);
      wr(tx_data_addr, 32'h00);
      rise_gap(gap);
      chk(gap, 32'h8);
      wait_flag(f_tend);
      $display("test carrier done");
      tally_and_finish;
   end
endmodule
`default_nettype wire

// ### dv/uart_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module uart_far_end #(
   parameter int bit_clks = 16
) (
   // Clock and serial lines
   input  wire logic clk,
   input  wire logic line_in,
   output logic      line_out
);
   logic [7:0] got_q [$];
   logic [7:0] b;
   initial line_out = 1'b1;
   // Frame sender, every low lasts whole bits of bit_clks clocks, far above three clocks
   task automatic send(input logic [7:0] d, input logic pen, podd, bad_par, bad_stop);
      logic [10:0] f;
      f = {1'b1, ^d ^ podd ^ bad_par, d, 1'b0};
      if (!pen) f[9] = !bad_stop;
      else f[10] = !bad_stop;
      for (int i = 0; i < 10 + pen; i++)
      begin
         line_out <= f[i];
         repeat (bit_clks) @(posedge clk);
      end
      line_out <= 1'b1;
      repeat (bit_clks) @(posedge clk);
   endtask
   // Receiver for 8 data bits, sampled mid bit
   initial
   begin
      forever
      begin
         @(negedge line_in);
         repeat (bit_clks / 2) @(posedge clk);
         for (int i = 0; i < 8; i++)
         begin
            repeat (bit_clks) @(posedge clk);
            b[i] = line_in;
         end
         got_q.push_back(b);
      end
   end
endmodule
`default_nettype wire

// ### logic/uart_core.sv
// Chosen here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module uart_core
   import uart_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Serial pins and request
   input  wire logic        serial_in_pin,
   output logic             serial_out_pin,
   output logic             irq
);
   typedef enum logic [1:0] {st_idle, st_start, st_bits, st_stop} ser_state_e;

   function automatic logic [3:0] frame_bits(input logic [mode_w-1:0] m);
      frame_bits = 4'h7 + {3'h0, m[dlen_pos]} + {3'h0, m[pen_pos]};
   endfunction

   // ----------------------------------------
   // Bus and registers
   // ----------------------------------------
   logic [7:0] a_q, a_d;
   logic wr_q, wr_d, rd_d;
   logic [clkc_w-1:0] clkc_q, clkc_d;
   logic [mode_w-1:0] mode_q, mode_d;
   logic [11:0] rate_q, rate_d;
   logic [7:0] car_q, car_d;
   logic en_q, en_d, srst_q, srst_d;
   logic [6:0] ien_q, ien_d;
   logic [6:0] flag_q, flag_d;
   logic [31:0] hrdata_d;
   logic irq_d;
   // Transmit
   ser_state_e ts_q, ts_d;
   logic [7:0] tbuf_q, tbuf_d, tsh_q, tsh_d;
   logic tfull_q, tfull_d, tbsy_q, tbsy_d, tbit_q, tbit_d, tpar_q, tpar_d;
   logic [3:0] tcnt_q, tcnt_d, ttk_q, ttk_d;
   // Receive
   ser_state_e rs_q, rs_d;
   logic [7:0] rsh_q, rsh_d;
   logic [3:0] rcnt_q, rcnt_d, rtk_q, rtk_d;
   logic rpar_q, rpar_d, rbsy_q, rbsy_d;
   logic [7:0] fifo_q [2];
   logic [7:0] fifo_d [2];
   logic [1:0] ferr_q, ferr_d, perr_q, perr_d;
   logic [1:0] cnt_q, cnt_d;
   // Rate, sync, modulators
   logic [7:0] bcnt_q, bcnt_d;
   logic [3:0] fcnt_q, fcnt_d;
   logic tick_q, tick_d;
   logic s1_q, s2_q;
   logic [4:0] irlo_q, irlo_d;
   logic [4:0] irst_q, irst_d;
   logic [7:0] ccnt_q, ccnt_d;
   logic cwave_q, cwave_d, out_d;

   logic wr_tx, rd_rx, rx_in, tx_line;

   always_comb
   begin
      a_d = a_q; wr_d = 1'b0; rd_d = 1'b0;
      if (hsel && hready && htrans[1])
      begin
         a_d = haddr;
         wr_d = hwrite;
         rd_d = !hwrite;
      end
      wr_tx = wr_q && a_q == tx_data_addr;
      rd_rx = rd_d && haddr == rx_data_addr;
      clkc_d = clkc_q; mode_d = mode_q; rate_d = rate_q; car_d = car_q;
      en_d = en_q; ien_d = ien_q; srst_d = 1'b0;
      if (wr_q)
         case (a_q)
            clock_ctrl_addr: if (!en_q) clkc_d = hwdata[clkc_w-1:0] & clkc_mask;
            mode_addr:       if (!en_q) mode_d = hwdata[mode_w-1:0] & 13'h1c1f;
            rate_addr:       if (!en_q) rate_d = hwdata[11:0];
            carrier_addr:    car_d = hwdata[7:0];
            control_addr:
            begin
               en_d = hwdata[0];
               srst_d = hwdata[1];
            end
            enable_addr:     ien_d = hwdata[6:0];
            default: ;
         endcase
      hrdata_d = 32'h0;
      if (rd_d)
         case (haddr)
            clock_ctrl_addr: hrdata_d = {23'h0, clkc_q};
            mode_addr:       hrdata_d = {19'h0, mode_q};
            rate_addr:       hrdata_d = {20'h0, rate_q};
            carrier_addr:    hrdata_d = {24'h0, car_q};
            control_addr:    hrdata_d = {30'h0, srst_q, en_q};
            rx_data_addr:    hrdata_d = {24'h0, fifo_q[0]};
            tx_data_addr:    hrdata_d = {24'h0, tbuf_q};
            flag_addr:       hrdata_d = {22'h0, rbsy_q, tbsy_q, 1'b0, flag_q};
            enable_addr:     hrdata_d = {25'h0, ien_q};
            default:         hrdata_d = 32'h0;
         endcase
      irq_d = |(flag_q & ien_q);
   end

   // ----------------------------------------
   // Baud generator, carrier, sync
   // ----------------------------------------
   always_comb
   begin
      bcnt_d = bcnt_q; fcnt_d = fcnt_q; tick_d = 1'b0;
      if (!en_q || srst_q)
      begin
         bcnt_d = 8'h0; fcnt_d = 4'h0;
      end
      else if (fcnt_q != 4'h0)
         fcnt_d = fcnt_q - 4'h1;
      else if (bcnt_q == rate_q[7:0])
      begin
         bcnt_d = 8'h0;
         tick_d = 1'b1;
         // Fine divider: rate_q[11:8] extra clocks after every tick
         fcnt_d = mode_q[div_pos] ? rate_q[11:8] : 4'h0;
      end
      else
         bcnt_d = bcnt_q + 8'h1;
      ccnt_d = ccnt_q + 8'h1; cwave_d = cwave_q;
      if (ccnt_q >= car_q)
      begin
         ccnt_d = 8'h0;
         cwave_d = !cwave_q;
      end
      // Infrared stretch: a low of 3+ clocks holds low for 16 ticks
      irlo_d = s2_q ? 5'h0 : (irlo_q == 5'h1f ? irlo_q : irlo_q + 5'h1);
      irst_d = irst_q;
      if (irlo_q == ir_min_clk - 5'h1 && !s2_q) irst_d = 5'h10;
      else if (tick_q && irst_q != 5'h0) irst_d = irst_q - 5'h1;
      rx_in = mode_q[ir_pos] ? (irst_q == 5'h0) : s2_q;
      tx_line = tbit_q;
      if (mode_q[ir_pos] && !tbit_q) tx_line = ttk_q >= ir_ticks;
      out_d = tx_line;
      if (mode_q[car_en_pos] && (tx_line == mode_q[car_sel_pos])) out_d = tx_line ^ cwave_q;
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   always_comb
   begin
      ts_d = ts_q; tbuf_d = tbuf_q; tsh_d = tsh_q; tfull_d = tfull_q;
      tbsy_d = tbsy_q; tbit_d = tbit_q; tpar_d = tpar_q; tcnt_d = tcnt_q; ttk_d = ttk_q;
      if (wr_tx)
      begin
         tbuf_d = hwdata[7:0];
         tfull_d = 1'b1;
      end
      if (tick_q) ttk_d = ttk_q + 4'h1;
      case (ts_q)
         st_idle:
            if (tfull_q && en_q)
            begin
               tsh_d = tbuf_q; tfull_d = 1'b0;
               tpar_d = mode_q[pmode_pos];
               ts_d = st_start; tbsy_d = 1'b1; tbit_d = 1'b0;
               ttk_d = 4'h0; tcnt_d = 4'h0;
            end
         st_start, st_bits:
            if (tick_q && ttk_q == ticks_last)
            begin
               if (tcnt_q == frame_bits(mode_q))
               begin
                  ts_d = st_stop; tbit_d = 1'b1; tcnt_d = 4'h0;
               end
               else
               begin
                  ts_d = st_bits;
                  tbit_d = (mode_q[pen_pos] && tcnt_q == frame_bits(mode_q) - 4'h1) ? tpar_q : tsh_q[0];
                  tpar_d = tpar_q ^ tsh_q[0];
                  tsh_d = {1'b0, tsh_q[7:1]};
                  tcnt_d = tcnt_q + 4'h1;
               end
            end
         st_stop:
            if (tick_q && ttk_q == ticks_last)
            begin
               if (tcnt_q == {3'h0, mode_q[stop_pos]})
               begin
                  ts_d = st_idle;
                  tbsy_d = tfull_q;
                  if (tfull_q) tbit_d = 1'b1;
               end
               else
                  tcnt_d = tcnt_q + 4'h1;
            end
         default: ts_d = st_idle;
      endcase
      if (srst_q)
      begin
         ts_d = st_idle; tfull_d = 1'b0; tbsy_d = 1'b0; tbit_d = 1'b1;
      end
   end

   // ----------------------------------------
   // Receiver and FIFO
   // ----------------------------------------
   logic done, load;
   always_comb
   begin
      rs_d = rs_q; rsh_d = rsh_q; rcnt_d = rcnt_q; rtk_d = rtk_q;
      rpar_d = rpar_q; rbsy_d = rbsy_q; done = 1'b0;
      if (tick_q) rtk_d = rtk_q + 4'h1;
      case (rs_q)
         st_idle:
            if (!rx_in && en_q)
            begin
               rs_d = st_start; rbsy_d = 1'b1; rtk_d = 4'h0;
            end
         st_start:
            if (tick_q && rtk_q == ticks_mid)
            begin
               if (rx_in) begin rs_d = st_idle; rbsy_d = 1'b0; end
               else begin rs_d = st_bits; rtk_d = 4'h0; rcnt_d = 4'h0; rsh_d = 8'h0;
                  rpar_d = mode_q[pmode_pos]; end
            end
         st_bits:
            if (tick_q && rtk_q == ticks_last)
            begin
               rpar_d = rpar_q ^ rx_in;
               if (!(mode_q[pen_pos] && rcnt_q == frame_bits(mode_q) - 4'h1))
                  rsh_d = mode_q[dlen_pos] ? {rx_in, rsh_q[7:1]} : {1'b0, rx_in, rsh_q[6:1]};
               rcnt_d = rcnt_q + 4'h1;
               if (rcnt_q == frame_bits(mode_q) - 4'h1) rs_d = st_stop;
            end
         st_stop:
            if (tick_q && rtk_q == ticks_last)
            begin
               rs_d = st_idle; rbsy_d = 1'b0; done = 1'b1;
            end
         default: rs_d = st_idle;
      endcase
      load = done && cnt_q != 2'h2;
      fifo_d = fifo_q; ferr_d = ferr_q; perr_d = perr_q; cnt_d = cnt_q;
      if (rd_rx && cnt_q != 2'h0)
      begin
         fifo_d[0] = fifo_q[1]; ferr_d = {1'b0, ferr_q[1]}; perr_d = {1'b0, perr_q[1]};
         cnt_d = cnt_q - 2'h1;
      end
      if (load)
      begin
         fifo_d[cnt_d[0]] = rsh_q;
         ferr_d[cnt_d[0]] = !rx_in;
         perr_d[cnt_d[0]] = mode_q[pen_pos] && rpar_q;
         cnt_d = cnt_d + 2'h1;
      end
      if (srst_q)
      begin
         rs_d = st_idle; rbsy_d = 1'b0; cnt_d = 2'h0; ferr_d = 2'h0; perr_d = 2'h0;
      end
   end

   // ----------------------------------------
   // Flags
   // ----------------------------------------
   always_comb
   begin
      flag_d = flag_q;
      if (wr_q && a_q == flag_addr)
         flag_d = flag_q & ~(hwdata[6:0] & 7'h78);
      if (rd_rx && cnt_q != 2'h0)
      begin
         flag_d[f_fe] = 1'b0; flag_d[f_pe] = 1'b0;
      end
      flag_d[f_tbe] = !tfull_d;
      flag_d[f_rb1] = cnt_d != 2'h0;
      flag_d[f_rb2] = cnt_d == 2'h2;
      if (ferr_d[0] && (load || cnt_d != cnt_q)) flag_d[f_fe] = 1'b1;
      if (perr_d[0] && (load || cnt_d != cnt_q)) flag_d[f_pe] = 1'b1;
      if (done && cnt_q == 2'h2) flag_d[f_oe] = 1'b1;
      if (ts_q == st_stop && ts_d == st_idle && !tfull_q) flag_d[f_tend] = 1'b1;
      if (srst_q) flag_d = flag_reset;
   end

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         a_q <= 8'h0; wr_q <= 1'b0; clkc_q <= '0; mode_q <= '0;
         rate_q <= 12'h0; car_q <= 8'h0; en_q <= 1'b0; srst_q <= 1'b0;
         ien_q <= 7'h0; flag_q <= flag_reset; hrdata <= 32'h0; irq <= 1'b0;
         ts_q <= st_idle; tbuf_q <= 8'h0; tsh_q <= 8'h0; tfull_q <= 1'b0;
         tbsy_q <= 1'b0; tbit_q <= 1'b1; tpar_q <= 1'b0; tcnt_q <= 4'h0; ttk_q <= 4'h0;
         rs_q <= st_idle; rsh_q <= 8'h0; rcnt_q <= 4'h0; rtk_q <= 4'h0;
         rpar_q <= 1'b0; rbsy_q <= 1'b0; fifo_q[0] <= 8'h0; fifo_q[1] <= 8'h0;
         ferr_q <= 2'h0; perr_q <= 2'h0; cnt_q <= 2'h0;
         bcnt_q <= 8'h0; fcnt_q <= 4'h0; tick_q <= 1'b0;
         s1_q <= 1'b1; s2_q <= 1'b1; irlo_q <= 5'h0; irst_q <= 5'h0;
         ccnt_q <= 8'h0; cwave_q <= 1'b0; serial_out_pin <= 1'b1;
      end
      else
      begin
         a_q <= a_d; wr_q <= wr_d; clkc_q <= clkc_d; mode_q <= mode_d;
         rate_q <= rate_d; car_q <= car_d; en_q <= en_d; srst_q <= srst_d;
         ien_q <= ien_d; flag_q <= flag_d; hrdata <= hrdata_d; irq <= irq_d;
         ts_q <= ts_d; tbuf_q <= tbuf_d; tsh_q <= tsh_d; tfull_q <= tfull_d;
         tbsy_q <= tbsy_d; tbit_q <= tbit_d; tpar_q <= tpar_d; tcnt_q <= tcnt_d; ttk_q <= ttk_d;
         rs_q <= rs_d; rsh_q <= rsh_d; rcnt_q <= rcnt_d; rtk_q <= rtk_d;
         rpar_q <= rpar_d; rbsy_q <= rbsy_d; fifo_q <= fifo_d;
         ferr_q <= ferr_d; perr_q <= perr_d; cnt_q <= cnt_d;
         bcnt_q <= bcnt_d; fcnt_q <= fcnt_d; tick_q <= tick_d;
         s1_q <= serial_in_pin; s2_q <= s1_q; irlo_q <= irlo_d; irst_q <= irst_d;
         ccnt_q <= ccnt_d; cwave_q <= cwave_d; serial_out_pin <= out_d;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule
`default_nettype wire

// ### logic/uart_pkg.sv
package uart_pkg;
   // ----------------------------------------
   // Register byte addresses
   // ----------------------------------------
   localparam logic [7:0] clock_ctrl_addr = 8'h00;
   localparam logic [7:0] mode_addr       = 8'h04;
   localparam logic [7:0] rate_addr       = 8'h08;
   localparam logic [7:0] control_addr    = 8'h0c;
   localparam logic [7:0] tx_data_addr    = 8'h10;
   localparam logic [7:0] rx_data_addr    = 8'h14;
   localparam logic [7:0] flag_addr       = 8'h18;
   localparam logic [7:0] enable_addr     = 8'h1c;
   localparam logic [7:0] carrier_addr    = 8'h20;
   // ----------------------------------------
   // Mode fields
   // ----------------------------------------
   localparam int stop_pos = 0;
   localparam int pmode_pos = 1;
   localparam int pen_pos = 2;
   localparam int dlen_pos = 3;
   localparam int ir_pos = 4;
   localparam int div_pos = 10;
   localparam int car_en_pos = 11;
   localparam int car_sel_pos = 12;
   localparam int mode_w = 13;
   localparam int clkc_w = 9;
   localparam logic [8:0] clkc_mask = 9'h133;
   // Flag bit positions
   localparam int f_tbe = 0;
   localparam int f_rb1 = 1;
   localparam int f_rb2 = 2;
   localparam int f_oe = 3;
   localparam int f_pe = 4;
   localparam int f_fe = 5;
   localparam int f_tend = 6;
   localparam int f_tbsy = 8;
   localparam int f_rbsy = 9;
   localparam logic [6:0] flag_reset = 7'h01;
   // Sample ticks per bit and IR pulse length
   localparam logic [3:0] ticks_last = 4'hf;
   localparam logic [3:0] ticks_mid = 4'h7;
   localparam logic [3:0] ir_ticks = 4'h3;
   localparam logic [4:0] ir_min_clk = 5'h03;
endpackage
